// ---- src/mcudec_defines.vh ----
// constants for the 14-bit instruction decode and execute block
// Notes on behaviour
// RL1 - byte 1101 rotates file left through carry
// RL2 - byte 1100 rotates file right through carry
// RL3 - 1011 decrements, skips on zero, no flags
// RL4 - 1111 increments, skips on zero, no flags
// RL5 - bit 10bb skips when selected bit clear
// RL6 - bit 11bb skips when selected bit set
// RL7 - byte 0100 ors acc with file, zero only
// RL8 - byte 0110 xors acc with file, zero only
// RL9 - literal 110x: literal minus acc, c dc z
// RL10 - literal 01xx loads acc and returns, two cycles
// RL11 - literal 1000 ors literal into acc, zero
// RL12 - literal 1010 xors literal into acc, zero
// RL13 - standby word sets watchdog flag, clears sleep flag
// RL14 - io read-modify-write uses pin levels
// RL15 - timer write with d=1 clears prescaler
// RL16 - pc change or true test costs two cycles
// RL17 - destination bit picks acc or file
// RL18 - call and jump use 11-bit target, two cycles
// RL19 - file minus acc by two's complement add
`ifndef MCUDEC_DEFINES_VH
`define MCUDEC_DEFINES_VH
`define MCUDEC_OP_MOVWF 4'h0
`define MCUDEC_OP_CLR 4'h1
`define MCUDEC_OP_SUBWF 4'h2
`define MCUDEC_OP_DECF 4'h3
`define MCUDEC_OP_OR_ACC_FILE_OP 4'h4
`define MCUDEC_OP_ANDWF 4'h5
`define MCUDEC_OP_XOR_ACC_FILE_OP 4'h6
`define MCUDEC_OP_ADDWF 4'h7
`define MCUDEC_OP_MOVF 4'h8
`define MCUDEC_OP_COMF 4'h9
`define MCUDEC_OP_INCF 4'ha
`define MCUDEC_OP_DECSZ 4'hb
`define MCUDEC_OP_RRF 4'hc
`define MCUDEC_OP_RLF 4'hd
`define MCUDEC_OP_SWAPF 4'he
`define MCUDEC_OP_INCSZ 4'hf
`define MCUDEC_W_RETURN 14'h0008
`define MCUDEC_W_RETFIE 14'h0009
`define MCUDEC_W_SLEEP 14'h0063
`define MCUDEC_W_CLRWDT 14'h0064
`define MCUDEC_ADDR_TIMER_ZERO 7'h01
`define MCUDEC_ADDR_PORTA 7'h05
`define MCUDEC_ADDR_PORTE 7'h09
`define MCUDEC_STACK_DEPTH 8
`define MCUDEC_RESET_VECTOR 13'h0000
`define MCUDEC_INT_VECTOR 13'h0004
`endif

// ---- src/mcudec_alu.v ----
// arithmetic and logic unit for byte and literal operations
`include "mcudec_defines.vh"
module mcudec_alu (
   input wire [3:0] op,
   input wire lit_mode,
   input wire [7:0] a,
   input wire [7:0] w,
   input wire c_in,
   output reg [7:0] res,
   output reg c_out,
   output reg dc_out,
   output wire z_out
);
   reg [8:0] sum;
   reg [4:0] nib;
   always @*
   begin
      sum = 9'h000;
      nib = 5'h00;
      res = a;
      c_out = c_in;
      dc_out = 1'b0;
      if (lit_mode)
      begin
         case (op)
            4'h8: res = a | w; // see RL11
            4'h9: res = a & w;
            4'ha: res = a ^ w; // see RL12
            4'hc, 4'hd:
            begin
               sum = {1'b0, a} + {1'b0, ~w} + 9'h001; // see RL9
               nib = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
               res = sum[7:0];
               c_out = sum[8];
               dc_out = nib[4];
            end
            4'he, 4'hf:
            begin
               sum = {1'b0, a} + {1'b0, w};
               nib = {1'b0, a[3:0]} + {1'b0, w[3:0]};
               res = sum[7:0];
               c_out = sum[8];
               dc_out = nib[4];
            end
            default: res = a;
         endcase
      end
      else
      begin
         case (op)
            `MCUDEC_OP_MOVWF: res = w;
            `MCUDEC_OP_CLR: res = 8'h00;
            `MCUDEC_OP_SUBWF:
            begin
               sum = {1'b0, a} + {1'b0, ~w} + 9'h001; // see RL19
               nib = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
               res = sum[7:0];
               c_out = sum[8];
               dc_out = nib[4];
            end
            `MCUDEC_OP_DECF, `MCUDEC_OP_DECSZ: res = a - 8'h01; // see RL3
            `MCUDEC_OP_OR_ACC_FILE_OP: res = a | w; // see RL7
            `MCUDEC_OP_ANDWF: res = a & w;
            `MCUDEC_OP_XOR_ACC_FILE_OP: res = a ^ w; // see RL8
            `MCUDEC_OP_ADDWF:
            begin
               sum = {1'b0, a} + {1'b0, w};
               nib = {1'b0, a[3:0]} + {1'b0, w[3:0]};
               res = sum[7:0];
               c_out = sum[8];
               dc_out = nib[4];
            end
            `MCUDEC_OP_MOVF: res = a;
            `MCUDEC_OP_COMF: res = ~a;
            `MCUDEC_OP_INCF, `MCUDEC_OP_INCSZ: res = a + 8'h01; // see RL4
            `MCUDEC_OP_RRF:
            begin
               res = {c_in, a[7:1]}; // see RL2
               c_out = a[0];
            end
            `MCUDEC_OP_RLF:
            begin
               res = {a[6:0], c_in}; // see RL1
               c_out = a[7];
            end
            `MCUDEC_OP_SWAPF: res = {a[3:0], a[7:4]};
            default: res = a;
         endcase
      end
   end
   assign z_out = (res == 8'h00);
endmodule

// ---- src/mcudec_stack.v ----
// eight-level return address stack in flip-flops
`include "mcudec_defines.vh"
module mcudec_stack (
   input wire clk,
   input wire rstn,
   input wire push,
   input wire pop,
   input wire [12:0] push_addr,
   output wire [12:0] top_addr
);
   reg [12:0] mem_q [0:`MCUDEC_STACK_DEPTH-1];
   reg [2:0] ptr_q;
   integer i;
   wire [2:0] top_idx;
   assign top_idx = ptr_q - 3'h1;
   assign top_addr = mem_q[top_idx];
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ptr_q <= 3'h0;
         for (i = 0; i < `MCUDEC_STACK_DEPTH; i = i + 1)
         begin
            mem_q[i] <= 13'h0000;
         end
      end
      else if (push)
      begin
         mem_q[ptr_q] <= push_addr;
         ptr_q <= ptr_q + 3'h1;
      end
      else if (pop)
      begin
         ptr_q <= top_idx;
      end
   end
endmodule

// ---- src/mcudec_core.v ----
// decode and execute of 14-bit instruction words, one word per instruction cycle
`include "mcudec_defines.vh"
module mcudec_core (
   input wire clk,
   input wire rstn,
   input wire instr_valid,
   input wire [13:0] instr,
   input wire [7:0] file_rdata,
   input wire [7:0] pin_rdata,
   input wire prescaler_on_timer,
   input wire wake,
   output reg [12:0] pc_q,
   output reg [6:0] file_addr_q,
   output reg [7:0] file_wdata_q,
   output reg file_we_q,
   output reg [7:0] acc_q,
   output reg carry_q,
   output reg nibble_flag_q,
   output reg zero_q,
   output reg watchdog_expired_flag_q,
   output reg sleep_entered_flag_q,
   output reg wdt_clear_q,
   output reg prescaler_clear_q,
   output reg sleeping_q,
   output reg busy_q
);
   localparam [2:0] ST_EXEC = 3'b001;
   localparam [2:0] ST_FLUSH = 3'b010;
   localparam [2:0] ST_SLEEP = 3'b100;

   reg [2:0] state_q;
   reg [2:0] state_d;

   // operand source for byte operations on ports
   function is_port;
      input [6:0] addr;
      begin
         is_port = (addr >= `MCUDEC_ADDR_PORTA) && (addr <= `MCUDEC_ADDR_PORTE);
      end
   endfunction

   wire [1:0] cls = instr[13:12];
   wire [3:0] op = instr[11:8];
   wire dest = instr[7];
   wire [6:0] faddr = instr[6:0];
   wire [2:0] bsel = instr[9:7];
   wire [7:0] lit = instr[7:0];
   wire is_byte = (cls == 2'b00);
   wire is_bit = (cls == 2'b01);
   wire is_jump = (cls == 2'b10);
   wire is_lit = (cls == 2'b11);

   // pins instead of latch when an io register modifies itself
   wire [7:0] operand = is_port(faddr) ? pin_rdata : file_rdata; // see RL14

   wire [7:0] alu_res;
   wire alu_c;
   wire alu_dc;
   wire alu_z;
   wire [12:0] stack_top;
   reg push;
   reg pop;

   mcudec_alu u_alu (
      .op(op),
      .lit_mode(is_lit),
      .a(is_lit ? lit : operand),
      .w(acc_q),
      .c_in(carry_q),
      .res(alu_res),
      .c_out(alu_c),
      .dc_out(alu_dc),
      .z_out(alu_z)
   );

   mcudec_stack u_stack (
      .clk(clk),
      .rstn(rstn),
      .push(push),
      .pop(pop),
      .push_addr(pc_q + 13'h0001),
      .top_addr(stack_top)
   );

   // byte operations that are plain no-ops or control words
   wire ctrl_word = is_byte && (op == `MCUDEC_OP_MOVWF) && !dest;
   wire is_return = ctrl_word && (instr == `MCUDEC_W_RETURN || instr == `MCUDEC_W_RETFIE);
   wire is_sleep = ctrl_word && (instr == `MCUDEC_W_SLEEP);
   wire is_clrwdt = ctrl_word && (instr == `MCUDEC_W_CLRWDT);
   wire bit_val = operand[bsel];
   wire skip_bit = is_bit && ((op[3:2] == 2'b10 && !bit_val) // see RL5
      || (op[3:2] == 2'b11 && bit_val)); // see RL6
   wire skip_cnt = is_byte && (op == `MCUDEC_OP_DECSZ || op == `MCUDEC_OP_INCSZ) && alu_z;
   wire is_return_with_literal_op = is_lit && (op[3:2] == 2'b01);

   // flag selection per operation
   reg upd_z;
   reg upd_c;
   reg upd_dc;
   always @*
   begin
      upd_z = 1'b0;
      upd_c = 1'b0;
      upd_dc = 1'b0;
      if (is_byte)
      begin
         case (op)
            `MCUDEC_OP_MOVWF, `MCUDEC_OP_DECSZ, `MCUDEC_OP_INCSZ, `MCUDEC_OP_SWAPF: upd_z = 1'b0;
            `MCUDEC_OP_RRF, `MCUDEC_OP_RLF: upd_c = 1'b1; // see RL1
            `MCUDEC_OP_SUBWF, `MCUDEC_OP_ADDWF:
            begin
               upd_z = 1'b1;
               upd_c = 1'b1;
               upd_dc = 1'b1;
            end
            default: upd_z = 1'b1; // see RL7
         endcase
      end
      else if (is_lit)
      begin
         case (op)
            4'h8, 4'h9, 4'ha: upd_z = 1'b1; // see RL11
            4'hc, 4'hd, 4'he, 4'hf:
            begin
               upd_z = 1'b1; // see RL9
               upd_c = 1'b1;
               upd_dc = 1'b1;
            end
            default: upd_z = 1'b0;
         endcase
      end
   end

   always @*
   begin
      state_d = state_q;
      push = 1'b0;
      pop = 1'b0;
      case (state_q)
         ST_EXEC:
         begin
            if (instr_valid)
            begin
               if (is_sleep)
                  state_d = ST_SLEEP;
               else if (is_jump || is_return || is_return_with_literal_op || skip_bit || skip_cnt)
                  state_d = ST_FLUSH; // see RL16
               push = is_jump && !instr[11]; // see RL18
               pop = is_return || is_return_with_literal_op; // see RL10
            end
         end
         ST_FLUSH: state_d = ST_EXEC;
         ST_SLEEP:
         begin
            if (wake)
               state_d = ST_EXEC;
         end
         default: state_d = ST_EXEC;
      endcase
   end

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= ST_EXEC;
         pc_q <= `MCUDEC_RESET_VECTOR;
         file_addr_q <= 7'h00;
         file_wdata_q <= 8'h00;
         file_we_q <= 1'b0;
         acc_q <= 8'h00;
         carry_q <= 1'b0;
         nibble_flag_q <= 1'b0;
         zero_q <= 1'b0;
         watchdog_expired_flag_q <= 1'b1;
         sleep_entered_flag_q <= 1'b1;
         wdt_clear_q <= 1'b0;
         prescaler_clear_q <= 1'b0;
         sleeping_q <= 1'b0;
         busy_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         file_we_q <= 1'b0;
         wdt_clear_q <= 1'b0;
         prescaler_clear_q <= 1'b0;
         sleeping_q <= (state_d == ST_SLEEP);
         busy_q <= (state_d == ST_FLUSH);
         if (state_q == ST_EXEC && instr_valid)
         begin
            pc_q <= pc_q + 13'h0001;
            if (is_jump)
               pc_q <= {pc_q[12:11], instr[10:0]}; // see RL18
            else if (is_return || is_return_with_literal_op)
               pc_q <= stack_top;
            else if (skip_bit || skip_cnt)
               pc_q <= pc_q + 13'h0002; // see RL3
            if (upd_z)
               zero_q <= alu_z;
            if (upd_c)
               carry_q <= alu_c;
            if (upd_dc)
               nibble_flag_q <= alu_dc;
            if (is_byte && !ctrl_word)
            begin
               if (dest || op == `MCUDEC_OP_MOVWF)
               begin
                  file_addr_q <= faddr; // see RL17
                  file_wdata_q <= alu_res;
                  file_we_q <= 1'b1;
                  if (faddr == `MCUDEC_ADDR_TIMER_ZERO && prescaler_on_timer)
                     prescaler_clear_q <= 1'b1; // see RL15
               end
               else
                  acc_q <= alu_res; // see RL17
            end
            else if (is_bit && !op[3])
            begin
               file_addr_q <= faddr;
               file_wdata_q <= op[2] ? (operand | (8'h01 << bsel))
                  : (operand & ~(8'h01 << bsel));
               file_we_q <= 1'b1;
               if (faddr == `MCUDEC_ADDR_TIMER_ZERO && prescaler_on_timer)
                  prescaler_clear_q <= 1'b1; // see RL15
            end
            else if (is_lit)
            begin
               if (op[3:2] == 2'b00 || is_return_with_literal_op)
                  acc_q <= lit; // see RL10
               else
                  acc_q <= alu_res; // see RL12
            end
            if (is_sleep)
            begin
               watchdog_expired_flag_q <= 1'b1; // see RL13
               sleep_entered_flag_q <= 1'b0;
               wdt_clear_q <= 1'b1;
            end
            if (is_clrwdt)
            begin
               watchdog_expired_flag_q <= 1'b1;
               sleep_entered_flag_q <= 1'b1;
               wdt_clear_q <= 1'b1;
            end
         end
      end
   end
endmodule

// ---- verification/mcudec_checker.sv ----
// port assertions for the decode core
module mcudec_checker (
   input wire logic clk,
   input wire logic rstn,
   input wire logic instr_valid,
   input wire logic [13:0] instr,
   input wire logic [7:0] file_rdata,
   input wire logic prescaler_on_timer,
   input wire logic [12:0] pc_q,
   input wire logic [7:0] acc_q,
   input wire logic carry_q,
   input wire logic zero_q,
   input wire logic watchdog_expired_flag_q,
   input wire logic sleep_entered_flag_q,
   input wire logic prescaler_clear_q,
   input wire logic sleeping_q,
   input wire logic busy_q
);
   timeunit 1ns;
   timeprecision 1ps;
   wire tk = instr_valid && !busy_q && !sleeping_q;
   // port operands come from the pins, which this checker cannot see
   wire tkf = tk && (instr[6:0] < 7'h05 || instr[6:0] > 7'h09);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   AST_ROT_LEFT: assert property (tkf && instr[13:8] == 6'h0d
      |=> carry_q == $past(file_rdata[7])) else $error("rotate left carry");
   AST_ROT_RIGHT: assert property (tkf && instr[13:8] == 6'h0c
      |=> carry_q == $past(file_rdata[0])) else $error("rotate right carry");
   AST_DEC_SKIP: assert property (tkf && instr[13:8] == 6'h0b && file_rdata == 8'h01
      |=> busy_q && $stable(carry_q) && $stable(zero_q)) else $error("dec skip");
   AST_BIT_CLR: assert property (tkf && instr[13:10] == 4'h6 && !file_rdata[instr[9:7]]
      |=> busy_q) else $error("bit clear skip");
   AST_BIT_SET: assert property (tkf && instr[13:10] == 4'h7 && file_rdata[instr[9:7]]
      |=> busy_q) else $error("bit set skip");
   AST_OR_ACC: assert property (tkf && instr[13:7] == 7'h08
      |=> acc_q == ($past(acc_q) | $past(file_rdata))) else $error("or into acc");
   AST_STANDBY: assert property (tk && instr == 14'h0063
      |=> sleeping_q && !sleep_entered_flag_q && watchdog_expired_flag_q) else $error("standby");
   AST_PRESCALE: assert property (tk && instr == 14'h0a81 && prescaler_on_timer
      |=> prescaler_clear_q) else $error("prescaler clear");
   AST_JUMP: assert property (tk && instr[13:12] == 2'b10
      |=> busy_q && pc_q[10:0] == $past(instr[10:0])) else $error("jump target");
   AST_DEAD: assert property (busy_q
      |=> !busy_q && $stable(acc_q)) else $error("dead cycle");
   AST_SKIP_PC: assert property (tkf && instr[13:8] == 6'h0b && file_rdata == 8'h01
      |=> pc_q == $past(pc_q) + 13'h0002) else $error("skip advance");
   cover property (tk && instr[13:8] == 6'h0b && file_rdata == 8'h01);
   cover property (tk && instr == 14'h0063);
   cover property (tk && instr[13:12] == 2'b10);
endmodule
bind mcudec_core mcudec_checker i_chk (.clk, .rstn, .instr_valid, .instr, .file_rdata,
   .prescaler_on_timer, .pc_q, .acc_q, .carry_q, .zero_q, .watchdog_expired_flag_q,
   .sleep_entered_flag_q, .prescaler_clear_q, .sleeping_q, .busy_q);

// ---- verification/mcudec_progmem.sv ----
// program memory model presenting the word at the program counter
module mcudec_progmem (
   input wire logic [12:0] pc,
   input wire logic stall,
   output logic instr_valid,
   output logic [13:0] instr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [13:0] mem [0:8191];
   initial foreach (mem[j]) mem[j] = 14'h0000;
   assign instr_valid = !stall;
   // a stalled memory shows no stale word
   assign instr = stall ? ~mem[pc] : mem[pc];
endmodule

// ---- verification/mcudec_core_bench.sv ----
// self-checking bench for the decode core with a reference model
module mcudec_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rstn = 0, stall = 0, pot = 0, wake = 0, instr_valid;
   logic [7:0] fv = 8'h00, pv = 8'h00, acc = 8'h00, f0;
   logic [13:0] instr, wd;
   logic [12:0] pc = 13'h0000;
   logic [12:0] stk [$];
   logic c = 0, dc = 0, z = 0;
   int failures = 0, checks = 0, cyc = 0, i, n;
   logic [5:0] tbl [28] = '{6'h0d, 6'h0c, 6'h0b, 6'h0f, 6'h04, 6'h06, 6'h02,
      6'h18, 6'h1b, 6'h1c, 6'h1f, 6'h38, 6'h3a, 6'h3c, 6'h00, 6'h01, 6'h03, 6'h05,
      6'h07, 6'h08, 6'h09, 6'h0a, 6'h0e, 6'h10, 6'h14, 6'h30, 6'h39, 6'h3e};
   wire [12:0] pc_q;
   wire [6:0] file_addr_q;
   wire [7:0] file_wdata_q, acc_q;
   wire file_we_q, carry_q, nibble_flag_q, zero_q, watchdog_expired_flag_q;
   wire sleep_entered_flag_q, wdt_clear_q, prescaler_clear_q, sleeping_q, busy_q;
   mcudec_progmem i_mem (.pc(pc_q), .stall, .instr_valid, .instr);
   mcudec_core i_dut (.clk, .rstn, .instr_valid, .instr, .file_rdata(fv), .pin_rdata(pv),
      .prescaler_on_timer(pot), .wake, .pc_q, .file_addr_q, .file_wdata_q, .file_we_q, .acc_q,
      .carry_q, .nibble_flag_q, .zero_q, .watchdog_expired_flag_q, .sleep_entered_flag_q,
      .wdt_clear_q, .prescaler_clear_q, .sleeping_q, .busy_q);
   always #2.5 clk = ~clk;
   task print_verdict;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         print_verdict();
      end
   end
   task chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e)
      begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   function automatic logic [7:0] sub(input logic [7:0] a, input logic [7:0] b);
      dc = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01 > 5'h0f;
      {c, sub} = {1'b0, a} + {1'b0, ~b} + 9'h001;
   endfunction
   function automatic logic [7:0] add(input logic [7:0] a, input logic [7:0] b);
      dc = {1'b0, a[3:0]} + {1'b0, b[3:0]} > 5'h0f;
      {c, add} = {1'b0, a} + {1'b0, b};
   endfunction
   task automatic step(input logic [13:0] w, input logic [7:0] fi);
      logic [7:0] f, r, k;
      logic sk, two, wf, pcl;
      logic [12:0] po;
      f = (w[6:0] >= 7'h05 && w[6:0] <= 7'h09) ? pv : fi;
      k = w[7:0];
      r = 8'h00;
      sk = 0;
      two = 0;
      wf = 0;
      pcl = w[13:12] == 2'b00 && w[6:0] == 7'h01 && w[7] && pot;
      po = pc;
      if ($urandom_range(3) == 0)
      begin
         stall = 1;
         @(posedge clk);
         #1;
         chk(pc_q, pc);
         stall = 0;
      end
      fv = fi;
      i_mem.mem[pc] = w;
      @(posedge clk);
      #1;
      pc = pc + 1;
      if (w[13:4] == 10'h006)
         r = 8'h00;
      else if (w[13:12] == 2'b00)
      begin
         case (w[11:8])
            4'hd: {c, r} = {f, c};
            4'hc: {r, c} = {c, f};
            4'hb: r = f - 8'h01;
            4'hf, 4'ha: r = f + 8'h01;
            4'h4: r = acc | f;
            4'h6: r = acc ^ f;
            4'h2: r = sub(f, acc);
            4'h0: r = acc;
            4'h1: r = 8'h00;
            4'h3: r = f - 8'h01;
            4'h5: r = acc & f;
            4'h7: r = add(f, acc);
            4'h9: r = ~f;
            4'he: r = {f[3:0], f[7:4]};
            default: r = f;
         endcase
         if (w[11:8] inside {[4'h1:4'ha]})
            z = r == 8'h00;
         sk = (w[11:8] == 4'hb || w[11:8] == 4'hf) && r == 8'h00;
         if (w[7])
            wf = 1;
         else
            acc = r;
      end
      else if (w[13:12] == 2'b01)
      begin
         r = f;
         r[w[9:7]] = w[10];
         wf = !w[11];
         if (w[11])
            sk = f[w[9:7]] == w[10];
      end
      else if (w[13:12] == 2'b10)
      begin
         if (!w[11])
            stk.push_back(pc);
         pc = {po[12:11], w[10:0]};
         two = 1;
      end
      else
      begin
         case (w[11:8])
            4'h8: acc = acc | k;
            4'ha: acc = acc ^ k;
            4'hc, 4'hd: acc = sub(k, acc);
            4'h9: acc = acc & k;
            4'he, 4'hf: acc = add(k, acc);
            default: acc = k;
         endcase
         if (w[11:8] inside {4'h8, 4'h9, 4'ha, [4'hc:4'hf]})
            z = acc == 8'h00;
         if (w[11:10] == 2'b01)
         begin
            pc = stk.pop_back();
            two = 1;
         end
      end
      two = two | sk;
      if (sk)
         pc = pc + 13'h0001;
      chk(acc_q, acc);
      chk({carry_q, nibble_flag_q, zero_q}, {c, dc, z});
      chk({file_we_q, file_we_q ? {file_addr_q, file_wdata_q} : 15'h0000},
         {wf, wf ? {w[6:0], r} : 15'h0000});
      chk(prescaler_clear_q, pcl);
      chk({busy_q, pc_q}, {two, pc});
      if (two)
      begin
         @(posedge clk);
         #1;
      end
   endtask
   initial
   begin
      void'($urandom(94259));
      repeat (4) @(posedge clk);
      #1;
      chk({watchdog_expired_flag_q, sleep_entered_flag_q, acc_q}, 10'h300);
      rstn = 1;
      step(14'h2123, 8'h00);
      step(14'h3456, 8'h00);
      step(14'h2a40, 8'h00);
      pv = 8'h3c;
      step(14'h0a85, 8'h7f);
      pot = 1;
      step(14'h0a81, 8'h10);
      pot = 0;
      step(14'h0a81, 8'h10);
      repeat (400)
      begin
         i = $urandom_range(27);
         wd = {tbl[i], 8'($urandom)};
         if (!wd[13])
            wd[6:0] = {2'b01, wd[4:0]};
         n = $urandom_range(3);
         f0 = n == 0 ? 8'h01 : n == 1 ? 8'hff : 8'($urandom);
         step(wd, f0);
      end
      step(14'h0064, 8'h00);
      chk({watchdog_expired_flag_q, sleep_entered_flag_q, wdt_clear_q}, 3'h7);
      step(14'h0063, 8'h00);
      chk({watchdog_expired_flag_q, sleep_entered_flag_q, sleeping_q}, 3'h5);
      @(posedge clk);
      #1;
      chk(pc_q, pc);
      wake = 1;
      for (n = 0; n < 10 && sleeping_q !== 1'b0; n++)
      begin
         @(posedge clk);
         #1;
      end
      chk(sleeping_q, 0);
      print_verdict();
   end
endmodule
